/* design/lmdt_consts.svh */
// Offsets, field positions, level codes and timing counts of the LCD timing
`ifndef LMDT_CONSTS_SVH
`define LMDT_CONSTS_SVH

// Register byte offsets on the APB
`define LMDT_REG_CTRL 4'h0
`define LMDT_REG_PTR 4'h4
`define LMDT_REG_RAM 4'h8
`define LMDT_REG_STAT 4'hC

// Control register fields
`define LMDT_CTRL_MODE 1:0
`define LMDT_CTRL_HALF 2
`define LMDT_CTRL_SAVE 3
`define LMDT_CTRL_EN 4
`define LMDT_CTRL_BLINK 6:5
`define LMDT_CTRL_INBANK 7
`define LMDT_CTRL_OUTBANK 8

// Pointer register fields
`define LMDT_PTR_ADDR 4:0
`define LMDT_PTR_SUB 7:5

// Geometry
`define LMDT_LAST_ADDR 5'h17

// Frame lengths in display clock periods (2880 and 480)
`define LMDT_FRAME_NORMAL 12'hB40
`define LMDT_FRAME_SAVE 12'h1E0

// Internal oscillator half period in system clocks, normal mode
`define LMDT_OSC_HALF 9'h036
// Power-saving divides the oscillator down by this factor
`define LMDT_SAVE_FACTOR 9'h006

// Level codes: supply, one third, two thirds, LCD supply
`define LMDT_LVL_VDD 2'h0
`define LMDT_LVL_THIRD 2'h1
`define LMDT_LVL_TWOTHIRD 2'h2
`define LMDT_LVL_LCD_DRIVE_SUPPLY 2'h3

`endif

/* design/lmdt_pkg.sv */
// Types shared by the LCD multiplex drive timing block
package lmdt_pkg;

   // Drive modes, in the order of their two-bit code
   typedef enum logic [1:0] {
      MODE_STATIC,
      MODE_MUX2,
      MODE_MUX3,
      MODE_MUX4
   } lmdt_mode_t;

   // Column fetch engine
   typedef enum logic {
      SH_IDLE,
      SH_RUN
   } lmdt_shift_t;

   // Whole state of the block
   typedef struct packed {
      lmdt_mode_t mode;
      logic halfBias;
      logic powerSave;
      logic enable;
      logic [1:0] blink;
      logic inBank;
      logic outBank;
      logic [4:0] ptr;
      logic [2:0] subAddr;
      logic [23:0][3:0] ram;
      logic [8:0] oscCnt;
      logic oscLevel;
      logic clkPrev;
      logic [11:0] slotCnt;
      logic [1:0] slotIdx;
      logic invert;
      lmdt_shift_t shState;
      logic [4:0] shIdx;
      logic [23:0] shiftReg;
      logic [23:0] latch;
      logic [3:0][1:0] bp;
      logic [23:0][1:0] seg;
      logic centreBypass;
      logic clkOe;
      logic syncOe;
      logic [31:0] prdata;
   } lmdt_state_t;

endpackage

/* design/lmdt_drive_timing.sv */
// LCD frame timing, column fetch and backplane/segment level generation
//
// Summary of operation
// - Backplane and segment outputs sit at supply level until enabled
// - Reset selects four-way multiplex, one-third bias
// - Reset clears blink, banks, pointer, subaddress
// - Half bias bypasses the centre divider
// - Control register writes set mode and bias
// - Half bias allowed in every drive mode
// - Strap low: internal oscillator drives clock pin
// - Strap high: clock pin is the timebase input
// - Frame is 2880 or 480 display clocks
// - Frame rate fixed on internal oscillator, follows pin clock
// - Shared sync line aligns cascaded frames
// - Stall RAM write until column fetch done
// - Fetch next column while latch is shown
// - Latch holds 24 bits, one per segment
// - Segment level from latch bit and phase
// - Backplane levels follow the drive mode
// - Three-way mode: plane 3 copies plane 1
// - Two-way mode: planes 2,3 copy 0,1
// - Static mode: all planes identical
// - Column n shows in slot of plane n
// - Columns fetched in order, bank offset applied
`timescale 1ns/1ps
`include "lmdt_consts.svh"

module lmdt_drive_timing (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock source strap and clock pin
   input wire logic clockSourceSelect,
   input wire logic clkPinIn,
   output logic clkPinOut,
   output logic clkPinOe,
   // Open-drain cascade sync line
   input wire logic syncIn,
   output logic syncOut,
   output logic syncOe,
   // LCD drive level codes and bias control
   output logic [3:0][1:0] backplane_outputs,
   output logic [23:0][1:0] segment_outputs,
   output logic centreBypass
);
   import lmdt_pkg::*;

   lmdt_state_t q; // Registered state
   lmdt_state_t d; // Next state

   ////////////////////////////////////////////////////////////////////////
   // Level functions

   // Backplane level for one plane
   function automatic logic [1:0] bpLevel(input logic sel, input logic inv,
         input logic half, input logic stat);
      logic [1:0] lvl;
      lvl = `LMDT_LVL_VDD;
      if (sel || stat) begin
         lvl = inv ? `LMDT_LVL_LCD_DRIVE_SUPPLY : `LMDT_LVL_VDD;
      end else if (half) begin
         // Centre resistor out, both inner taps merge
         lvl = `LMDT_LVL_THIRD;
      end else begin
         lvl = inv ? `LMDT_LVL_THIRD : `LMDT_LVL_TWOTHIRD;
      end
      return lvl;
   endfunction

   // Segment level for one latched bit
   function automatic logic [1:0] segLevel(input logic on, input logic inv,
         input logic half, input logic stat);
      logic [1:0] lvl;
      lvl = `LMDT_LVL_VDD;
      if (on) begin
         lvl = inv ? `LMDT_LVL_VDD : `LMDT_LVL_LCD_DRIVE_SUPPLY;
      end else if (stat || half) begin
         lvl = inv ? `LMDT_LVL_LCD_DRIVE_SUPPLY : `LMDT_LVL_VDD;
      end else begin
         lvl = inv ? `LMDT_LVL_TWOTHIRD : `LMDT_LVL_THIRD;
      end
      return lvl;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Per-plane and per-segment levels

   logic [3:0][1:0] bpNext; // Levels for the next cycle
   logic [23:0][1:0] segNext;
   logic isStatic; // Static drive in force

   assign isStatic = (q.mode == MODE_STATIC);

   genvar gi;
   generate
      // Each plane picks the slot it belongs to
      for (gi = 0; gi < 4; gi++) begin : g_bp
         logic [1:0] slotOf;
         always_comb begin
            unique case (q.mode)
               MODE_STATIC: slotOf = 2'h0;
               MODE_MUX2: slotOf = {1'b0, gi[0]};
               MODE_MUX3: slotOf = (gi == 3) ? 2'h1 : gi[1:0];
               MODE_MUX4: slotOf = gi[1:0];
            endcase
         end
         assign bpNext[gi] = bpLevel(slotOf == q.slotIdx, q.invert,
            q.halfBias, isStatic);
      end
      // Each segment from its latched bit and the phase
      for (gi = 0; gi < 24; gi++) begin : g_seg
         assign segNext[gi] = segLevel(q.latch[gi], q.invert, q.halfBias,
            isStatic);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Timebase helpers

   logic [8:0] oscHalf; // Oscillator half period in use
   logic oscRise; // Internal clock rising this cycle
   logic tick; // One display clock period elapsed
   logic [11:0] slotLen; // Display clocks per slot
   logic slotEnd; // Last tick of a slot
   logic frameStart; // First tick of a frame
   logic foreignSync; // Another driver pulls sync low
   logic [1:0] followSlot; // Slot after the current one
   logic [1:0] fetchCol; // RAM column to prefetch

   // Power-saving slows the oscillator so the frame rate stays put
   assign oscHalf = q.powerSave ? 9'(`LMDT_OSC_HALF * `LMDT_SAVE_FACTOR)
      : `LMDT_OSC_HALF;
   assign oscRise = (q.oscCnt == oscHalf - 9'h001) && !q.oscLevel;
   // Pin edges are the timebase when the strap is high
   assign tick = clockSourceSelect ? (clkPinIn && !q.clkPrev)
      : oscRise;

   // Half a frame split evenly over the active planes
   always_comb begin
      unique case (q.mode)
         MODE_STATIC: slotLen = (q.powerSave ? `LMDT_FRAME_SAVE
            : `LMDT_FRAME_NORMAL) / 12'h2;
         MODE_MUX2: slotLen = (q.powerSave ? `LMDT_FRAME_SAVE
            : `LMDT_FRAME_NORMAL) / 12'h4;
         MODE_MUX3: slotLen = (q.powerSave ? `LMDT_FRAME_SAVE
            : `LMDT_FRAME_NORMAL) / 12'h6;
         MODE_MUX4: slotLen = (q.powerSave ? `LMDT_FRAME_SAVE
            : `LMDT_FRAME_NORMAL) / 12'h8;
      endcase
   end

   // A shorter slot after a mode change ends at once, not after a wrap
   assign slotEnd = (tick && (q.slotCnt >= slotLen - 12'h001))
      || (q.slotCnt >= slotLen);
   assign frameStart = (q.slotIdx == 2'h0) && !q.invert
      && (q.slotCnt == 12'h000);
   // Our own pull shows on the line too, so ignore it
   assign foreignSync = !syncIn && !q.syncOe && !frameStart;
   assign followSlot = (q.slotIdx == q.mode) ? 2'h0 : q.slotIdx + 2'h1;
   // Bank switch only exists in static and two-way modes
   assign fetchCol = followSlot + (((q.mode == MODE_STATIC
      || q.mode == MODE_MUX2) && q.outBank) ? 2'h2 : 2'h0);

   ////////////////////////////////////////////////////////////////////////
   // APB decode

   logic mapped; // Address hits a register
   logic access; // Access phase
   logic ramWrite; // Access phase of a RAM write
   logic stall; // RAM write must wait
   logic done; // Transfer completes this edge
   logic [3:0] regSel; // Register offset

   assign regSel = paddr[3:0];
   assign mapped = (paddr[31:4] == 28'h0000000) && (paddr[1:0] == 2'h0);
   assign access = psel && penable;
   assign ramWrite = access && pwrite && mapped
      && (regSel == `LMDT_REG_RAM);
   // Hold the write off while the fetch reads the array
   assign stall = ramWrite && (q.shState == SH_RUN);
   assign pready = !stall;
   assign pslverr = access && !mapped;
   assign done = access && pready && mapped;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   // All state updates in one place
   always_comb begin
      d = q;

      // Register writes
      if (done && pwrite) begin
         unique case (regSel)
            `LMDT_REG_CTRL: begin
               d.mode = lmdt_mode_t'(pwdata[`LMDT_CTRL_MODE]);
               d.halfBias = pwdata[`LMDT_CTRL_HALF];
               d.powerSave = pwdata[`LMDT_CTRL_SAVE];
               d.enable = pwdata[`LMDT_CTRL_EN];
               d.blink = pwdata[`LMDT_CTRL_BLINK];
               d.inBank = pwdata[`LMDT_CTRL_INBANK];
               d.outBank = pwdata[`LMDT_CTRL_OUTBANK];
            end
            `LMDT_REG_PTR: begin
               d.ptr = pwdata[`LMDT_PTR_ADDR];
               d.subAddr = pwdata[`LMDT_PTR_SUB];
            end
            `LMDT_REG_RAM: begin
               // Out-of-range pointer stores nothing but still steps
               if (q.ptr <= `LMDT_LAST_ADDR) begin
                  if (q.inBank && (q.mode == MODE_STATIC
                        || q.mode == MODE_MUX2)) begin
                     d.ram[q.ptr][3:2] = pwdata[1:0];
                  end else begin
                     d.ram[q.ptr] = pwdata[3:0];
                  end
               end
               if (q.ptr >= `LMDT_LAST_ADDR) begin
                  d.ptr = 5'h00;
                  d.subAddr = q.subAddr + 3'h1;
               end else begin
                  d.ptr = q.ptr + 5'h01;
               end
            end
            default: begin
               // Status is read-only
            end
         endcase
      end

      // Read data prepared in the setup cycle
      if (psel && !penable) begin
         d.prdata = 32'h00000000;
         if (mapped) begin
            unique case (regSel)
               `LMDT_REG_CTRL: d.prdata = {23'h000000, q.outBank,
                  q.inBank, q.blink, q.enable, q.powerSave, q.halfBias,
                  q.mode};
               `LMDT_REG_PTR: d.prdata = {24'h000000, q.subAddr, q.ptr};
               `LMDT_REG_RAM: d.prdata = {28'h0000000,
                  (q.ptr <= `LMDT_LAST_ADDR) ? q.ram[q.ptr] : 4'h0};
               `LMDT_REG_STAT: d.prdata = {26'h0000000, q.slotIdx,
                  q.invert, clockSourceSelect, q.shState == SH_RUN,
                  q.enable};
               default: d.prdata = 32'h00000000;
            endcase
         end
      end

      // Internal oscillator divider
      if (q.oscCnt >= oscHalf - 9'h001) begin
         d.oscCnt = 9'h000;
         d.oscLevel = !q.oscLevel;
      end else begin
         d.oscCnt = q.oscCnt + 9'h001;
      end
      d.clkPrev = clkPinIn;
      d.clkOe = !clockSourceSelect;

      // Slot and frame-half counting
      if (foreignSync) begin
         d.slotCnt = 12'h000;
         d.slotIdx = 2'h0;
         d.invert = 1'b0;
      end else if (slotEnd) begin
         d.slotCnt = 12'h000;
         if (q.slotIdx >= q.mode) begin
            d.slotIdx = 2'h0;
            d.invert = !q.invert;
         end else begin
            d.slotIdx = q.slotIdx + 2'h1;
         end
      end else if (tick) begin
         d.slotCnt = q.slotCnt + 12'h001;
      end
      d.syncOe = frameStart && q.enable;

      // Latch reload and column prefetch
      if (slotEnd && !foreignSync) begin
         d.latch = q.shiftReg;
         d.shState = SH_RUN;
         d.shIdx = 5'h00;
      end else begin
         unique case (q.shState)
            SH_IDLE: d.shIdx = 5'h00;
            SH_RUN: begin
               d.shiftReg[q.shIdx] = q.ram[q.shIdx][fetchCol];
               if (q.shIdx >= `LMDT_LAST_ADDR) begin
                  d.shState = SH_IDLE;
               end else begin
                  d.shIdx = q.shIdx + 5'h01;
               end
            end
         endcase
      end

      // Drive levels, parked at supply while disabled
      if (q.enable) begin
         d.bp = bpNext;
         d.seg = segNext;
      end else begin
         d.bp = '0;
         d.seg = '0;
      end
      d.centreBypass = q.halfBias;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   // Reset values give the power-on display condition
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.mode <= MODE_MUX4;
         q.halfBias <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops, sync data tied low
   assign prdata = q.prdata;
   assign clkPinOut = q.oscLevel;
   assign clkPinOe = q.clkOe;
   assign syncOut = 1'b0;
   assign syncOe = q.syncOe;
   assign backplane_outputs = q.bp;
   assign segment_outputs = q.seg;
   assign centreBypass = q.centreBypass;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   // Disabled display parks every backplane and segment output at the supply
   property p_park;
      !q.enable |=> (backplane_outputs == '0) && (segment_outputs == '0);
   endproperty
   a_park: assert property (p_park)
      else $error("outputs not parked while disabled");

   // Three-way mode mirrors plane 1 on plane 3
   property p_mux3;
      (q.mode == MODE_MUX3) && q.enable ##1 $stable(q.mode)
         |-> backplane_outputs[3] == backplane_outputs[1];
   endproperty
   a_mux3: assert property (p_mux3)
      else $error("plane 3 differs from plane 1");

   // Two-way mode pairs the planes
   property p_mux2;
      (q.mode == MODE_MUX2) && q.enable ##1 $stable(q.mode)
         |-> backplane_outputs[2] == backplane_outputs[0]
         && backplane_outputs[3] == backplane_outputs[1];
   endproperty
   a_mux2: assert property (p_mux2)
      else $error("two-way plane pairs differ");

   // Static mode drives all planes alike
   property p_static;
      isStatic && q.enable ##1 $stable(q.mode)
         |-> backplane_outputs[0] == backplane_outputs[1]
         && backplane_outputs[2] == backplane_outputs[3]
         && backplane_outputs[0] == backplane_outputs[2];
   endproperty
   a_static: assert property (p_static)
      else $error("static planes differ");

   // Slot counter stays inside its slot length
   property p_slot;
      ##1 $stable(q.mode) && $stable(q.powerSave) |-> q.slotCnt < slotLen;
   endproperty
   a_slot: assert property (p_slot)
      else $error("slot counter overran");

   // RAM write is held off during the fetch
   property p_stall;
      ramWrite && q.shState == SH_RUN |-> !pready ##1 $stable(q.ram);
   endproperty
   a_stall: assert property (p_stall)
      else $error("RAM write taken during fetch");

   // Latch takes the prefetched column at a slot boundary
   property p_reload;
      slotEnd && !foreignSync |=> q.latch == $past(q.shiftReg)
         ##24 q.shState == SH_IDLE;
   endproperty
   a_reload: assert property (p_reload)
      else $error("latch reload or fetch length wrong");

   // Clock pin direction follows the strap
   property p_clkdir;
      $stable(clockSourceSelect) [*3] |-> clkPinOe == !clockSourceSelect;
   endproperty
   a_clkdir: assert property (p_clkdir)
      else $error("clock pin direction wrong");

   // Sync is only pulled at a frame start
   property p_sync;
      syncOe |-> $past(frameStart) && $past(q.enable);
   endproperty
   a_sync: assert property (p_sync)
      else $error("sync pulled outside frame start");

   // Half bias bypasses the centre divider
   property p_bias;
      q.halfBias [*2] |-> centreBypass;
   endproperty
   a_bias: assert property (p_bias)
      else $error("centre bypass not following bias");

endmodule

/* tb/lmdt_cascade_peer.sv */
// Cascade peer model: external clock source and open-drain sync puller
`timescale 1ns/1ps

module lmdt_cascade_peer (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Bench control
   input wire logic run,
   input wire logic pullSync,
   // Lines towards the driver
   output logic extClk,
   output logic syncPull
);

   ////////////////////////////////////////////////////////////////////////
   // Clock for the driver, one tick per two system clocks
   // Fastest rate the synchronous edge detect can still resolve
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         extClk <= 1'b0;
      end else begin
         extClk <= run ? ~extClk : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pulls the shared sync line low like another driver in the cascade
   assign syncPull = pullSync;

endmodule

/* tb/tb.sv */
// Self-checking bench for the LCD multiplex drive timing block
`timescale 1ns/1ps

module tb;

   ////////////////////////////////////////////////////////////////////////
   // Bench signals
   logic clock, reset_n, psel, penable, pwrite;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic pready, pslverr, err, strap, extClk, clkPinOut, clkPinOe;
   logic syncOut, syncOe, syncPull, syncLine, centreBypass, run, pullSync;
   logic [3:0][1:0] bp;
   logic [23:0][1:0] seg;
   logic [1:0] seen;
   logic [3:0] ram [24]; // Model of the display RAM
   int errors, compares, seed, k, m, v;

   // Open-drain sync: low while anyone pulls
   assign syncLine = ~((syncOe & ~syncOut) | syncPull);

   lmdt_drive_timing DUT (.clock(clock), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clockSourceSelect(strap), .clkPinIn(extClk), .clkPinOut(clkPinOut),
      .clkPinOe(clkPinOe), .syncIn(syncLine), .syncOut(syncOut),
      .syncOe(syncOe), .backplane_outputs(bp), .segment_outputs(seg),
      .centreBypass(centreBypass));

   lmdt_cascade_peer peer (.clock(clock), .reset_n(reset_n), .run(run),
      .pullSync(pullSync), .extClk(extClk), .syncPull(syncPull));

   ////////////////////////////////////////////////////////////////////////
   // Clock, 50 ns period
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Verdict and end of run
   task automatic close_out();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Compare and report
   task automatic check(string what, logic [63:0] got, logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; read data and error land in rd and err
   task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
      int i;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Stalled RAM writes may hold pready low for a column fetch
      for (i = 0; i < 100; i++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (i == 100) begin
         errors++;
         close_out();
      end
      // Answer taken at the completing edge, request released there
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reset with a given strap; levels must sit at supply code
   task automatic do_reset(logic s);
      reset_n <= 1'b0;
      strap <= s;
      repeat (10) @(posedge clock);
      check("bp in reset", bp, 0);
      reset_n <= 1'b1;
      repeat (2) @(negedge clock);
      check("clock pin enable", clkPinOe, !s);
      check("seg idle", seg, 0);
   endtask

   // Watch one mode over a frame; b is the shown RAM bit in static mode
   task automatic sample(int md, logic h, int b);
      logic [3:0][1:0] prev;
      logic [3:0] lv;
      int i, j;
      // Let a whole frame pass so the latch holds real data
      repeat (6000) @(posedge clock);
      prev = bp;
      lv = 0;
      for (i = 0; i < 6000; i++) begin
         @(negedge clock);
         lv[bp[0]] = 1'b1;
         // Skip the cycle of a level change, outputs may skew by one
         if (bp == prev) begin
            check("bias", centreBypass, h);
            if (md == 0) check("static", bp, {4{bp[0]}});
            if (md == 1) check("mux2", bp[3:2], bp[1:0]);
            if (md == 2) check("mux3", bp[3], bp[1]);
            for (j = 0; j < 24 && md == 0; j++) begin
               check("segment", seg[j], ram[j][b] ? 2'h3 - bp[0] : bp[0]);
            end
         end
         prev = bp;
      end
      check("polarity", lv[0] & lv[3], 1);
   endtask

   // Count clock-pin ticks between two frame starts
   task automatic frame(int exp);
      int i, t, r;
      logic pc, ps;
      t = 0;
      r = 0;
      pc = extClk;
      ps = syncOe;
      for (i = 0; i < 20000 && r < 2; i++) begin
         @(negedge clock);
         if (extClk && !pc && r == 1) t++;
         if (syncOe && !ps) r++;
         pc = extClk;
         ps = syncOe;
      end
      if (r < 2) begin
         errors++;
         close_out();
      end
      check("frame ticks", t, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      strap = 1'b0;
      run = 1'b0;
      pullSync = 1'b0;
      errors = 0;
      compares = 0;
      seed = 96527;
      seen = 2'h0;
      // Internal oscillator must toggle on the clock pin
      do_reset(1'b0);
      for (k = 0; k < 240; k++) begin
         @(negedge clock);
         seen[clkPinOut] = 1'b1;
      end
      check("oscillator", seen, 3);
      apb(1'b0, 32'h0, 0);
      check("ctrl reset", rd, 32'h3);
      apb(1'b0, 32'h4, 0);
      check("ptr reset", rd, 32'h0);
      // Second reset in mid-run, external clock from the peer
      do_reset(1'b1);
      run <= 1'b1;
      apb(1'b0, 32'h10, 0);
      check("unmapped err", err, 1);
      apb(1'b0, 32'h2, 0);
      check("misaligned err", {err, rd}, {1'b1, 32'h0});
      // Fill the RAM with random columns, then read it back
      apb(1'b1, 32'h4, 0);
      for (k = 0; k < 24; k++) begin
         v = $random(seed);
         ram[k] = v[3:0];
         apb(1'b1, 32'h8, {28'h0, ram[k]});
      end
      for (k = 0; k < 24; k++) begin
         apb(1'b1, 32'h4, k);
         apb(1'b0, 32'h8, 0);
         check("ram word", rd, {28'h0, ram[k]});
      end
      // Every drive mode, half bias on 2-way and 4-way
      for (m = 0; m < 4; m++) begin
         apb(1'b1, 32'h0, 32'h10 | m | ((m & 1) << 2));
         sample(m, m & 1, 0);
      end
      // Static with the alternate output bank
      apb(1'b1, 32'h0, 32'h110);
      sample(0, 1'b0, 2);
      // Frame length, normal then power saving
      apb(1'b1, 32'h0, 32'h13);
      frame(2880);
      apb(1'b1, 32'h0, 32'h1B);
      frame(480);
      // Foreign sync pulse, frame length must hold afterwards
      @(posedge clock);
      pullSync <= 1'b1;
      @(posedge clock);
      pullSync <= 1'b0;
      frame(480);
      close_out();
   end

endmodule
